// ==== inc/fsmf_consts.vh ====
// Constants for the fan speed monitor and fault control core
// Summary of operation
// RULE1: After power-up or shutdown exit the fan output runs at full duty.
// RULE2: Full duty lasts one second, then the selected duty source governs.
// RULE3: Only the shutdown bit stops the fan output.
// RULE4: A low-speed fault leaves the fan output pulsing at its duty.
// RULE5: Config bit 5 picks analog duty (0, default) or the duty register (1).
// RULE6: Duty codes 0 to 15 map linearly from 30% to 100%.
// RULE7: Config bits 2-1 select 1, 2, 4 or 8 tach pulses per turn, default 2.
// RULE8: Field codes 00,01,10,11 mean 1,2,4,8 pulses; reset value 01.
// RULE9: Speed counts tach pulses over a fixed gate, scaled by pulses per turn.
// RULE10: Speed is held in a 9-bit read-only register, LSB worth 25 RPM.
// RULE11: Config bit 6 set gives 25 RPM reading; clear gives 8 bits at 50 RPM.
// RULE12: Speed above 12775 RPM sets the overflow flag, status bit 3.
// RULE13: Overflow flag clears itself after 2.4 s below the maximum.
// RULE14: Fault threshold is an 8-bit read/write register, reset to 500 RPM.
// RULE15: Fan fault is declared after speed stays below threshold for 2.4 s.
// RULE16: Fan fault drives the fault output low and sets status bit 0.
// RULE17: Writing 1 to config bit 7 releases the fault and clears status bit 0.
// RULE18: Duty demand above 100% sets status bit 5 and may pull fault low.
// RULE19: When demand drops back, over-temperature flag and fault are released.
// RULE20: Shutdown suspends everything except the serial register interface.
// RULE21: Clearing shutdown resumes at once, starting with full duty.
// RULE22: Shutdown exit restores defaults except config and threshold.
// RULE23: The device answers only to the fixed 7-bit address 0011011.
// RULE24: The master starts a transfer only while the bus is idle.
// RULE25: Data changes only while clock is low; else it is start or stop.
`ifndef FSMF_CONSTS_VH
`define FSMF_CONSTS_VH

// Clock rate and documented times
`define FSMF_CLK_HZ        200000000
`define FSMF_CLK_PER_MS    200000
`define FSMF_STARTUP_MS    1000
`define FSMF_HOLD_MS       2400

// PWM frame: 150 steps, 45 steps at code 0 plus 7 per code
`define FSMF_PWM_STEPS     8'h96
`define FSMF_PWM_BASE      8'h2D
`define FSMF_PWM_SLOPE     8'h07
`define FSMF_PWM_STEP_CYC  222222

// Serial bus
`define FSMF_SLAVE_ADDR    7'h1B

// Command codes (register selectors)
`define FSMF_CMD_SPEED     8'h00
`define FSMF_CMD_SPEED_LSB 8'h01
`define FSMF_CMD_CFG       8'h02
`define FSMF_CMD_STATUS    8'h03
`define FSMF_CMD_DUTY      8'h04
`define FSMF_CMD_THR       8'h05

// Configuration fields
`define FSMF_CFG_SDN       0
`define FSMF_CFG_PPR_LO    1
`define FSMF_CFG_PPR_HI    2
`define FSMF_CFG_DSRC      5
`define FSMF_CFG_FINE      6
`define FSMF_CFG_FAN_FAILURE_CLEAR_BIT     7

// Status fields
`define FSMF_ST_FF         0
`define FSMF_ST_RCO        3
`define FSMF_ST_OTF        5

// Reset values
`define FSMF_CFG_RST       8'h02
`define FSMF_THR_RST       8'h0A
`define FSMF_DUTY_RST      4'h2
`define FSMF_SPEED_MAX     9'h1FF

`endif

// ==== core/fsmf_core.v ====
// Fan speed monitor, PWM drive and fault control with serial register slave
`include "fsmf_consts.vh"
`default_nettype none

module fsmf_core #(
  parameter STARTUP_CYC  = `FSMF_CLK_PER_MS * `FSMF_STARTUP_MS,
  parameter GATE_CYC     = `FSMF_CLK_PER_MS * `FSMF_HOLD_MS,
  parameter PWM_STEP_CYC = `FSMF_PWM_STEP_CYC,
  parameter OT_FAULT_EN  = 1
) (
  input  wire       mclk,          // 200 MHz core clock
  input  wire       reset,         // Async reset, active high
  input  wire       sclIn,         // Serial clock pin
  input  wire       sdaIn,         // Serial data pin level
  output wire       sdaOut,        // Serial data drive value
  output wire       sdaOe,         // Serial data drive enable
  input  wire       senseIn,       // Tach comparator output
  input  wire [3:0] tempDutyCode,  // Analog derived duty code
  input  wire       tempOverRange, // Analog demand above full scale
  output wire       pwmDriveOut,   // Fan PWM drive
  output wire       faultOut_n     // Fault output, active low
);

  // ***************************************************************
  // Input synchronisers
  // ***************************************************************
  localparam ST_IDLE = 5'h01;
  localparam ST_RX   = 5'h02;
  localparam ST_ACK  = 5'h04;
  localparam ST_TX   = 5'h08;
  localparam ST_MACK = 5'h10;

  reg  [1:0] sclSync_r;
  reg  [1:0] sdaSync_r;
  reg  [1:0] senseSync_r;
  reg  [3:0] tcode0_r;
  reg  [3:0] tcode1_r;
  reg        over0_r;
  reg        over1_r;
  reg        sclPrev_r;
  reg        sdaPrev_r;
  reg        sensePrev_r;

  // Two flops on every pin; only the second stage is read
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sclSync_r   <= 2'h3;
      sdaSync_r   <= 2'h3;
      senseSync_r <= 2'h0;
      tcode0_r    <= 4'h0;
      tcode1_r    <= 4'h0;
      over0_r     <= 1'b0;
      over1_r     <= 1'b0;
      sclPrev_r   <= 1'b1;
      sdaPrev_r   <= 1'b1;
      sensePrev_r <= 1'b0;
    end
    else
    begin
      sclSync_r   <= {sclSync_r[0], sclIn};
      sdaSync_r   <= {sdaSync_r[0], sdaIn};
      senseSync_r <= {senseSync_r[0], senseIn};
      tcode0_r    <= tempDutyCode;
      tcode1_r    <= tcode0_r;
      over0_r     <= tempOverRange;
      over1_r     <= over0_r;
      sclPrev_r   <= sclSync_r[1];
      sdaPrev_r   <= sdaSync_r[1];
      sensePrev_r <= senseSync_r[1];
    end
  end

  wire sclS    = sclSync_r[1];
  wire sdaS    = sdaSync_r[1];
  wire sclRise = sclS & ~sclPrev_r;
  wire sclFall = ~sclS & sclPrev_r;
  // SDA moving while SCL is high marks start or stop [RULE25]
  wire startC  = sclS & sclPrev_r & sdaPrev_r & ~sdaS;
  wire stopC   = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
  wire tachP   = senseSync_r[1] & ~sensePrev_r;

  // ***************************************************************
  // Register file
  // ***************************************************************
  reg  [7:0] cfg_r;
  reg  [7:0] thr_r;
  reg  [3:0] duty_r;
  reg  [8:0] speed_r;
  reg        ff_r;
  reg        rco_r;
  reg        otf_r;
  reg        wrEn_r;
  reg  [7:0] wrData_r;
  reg  [7:0] cmd_r;
  reg  [7:0] rdData;

  wire sdn     = cfg_r[`FSMF_CFG_SDN];
  wire wrCfg   = wrEn_r & (cmd_r == `FSMF_CMD_CFG);
  wire ffClear = wrCfg & wrData_r[`FSMF_CFG_FAN_FAILURE_CLEAR_BIT];

  // Config and threshold survive shutdown; clear bit never stored [RULE22] [RULE14]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      cfg_r <= `FSMF_CFG_RST; // [RULE8] [RULE5] [RULE11]
      thr_r <= `FSMF_THR_RST;
    end
    else if (wrEn_r)
    begin
      if (cmd_r == `FSMF_CMD_CFG)
        cfg_r <= {1'b0, wrData_r[6:0]};
      if (cmd_r == `FSMF_CMD_THR)
        thr_r <= wrData_r;
    end
  end

  // Duty register returns to default while shut down [RULE22]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
      duty_r <= `FSMF_DUTY_RST;
    else if (sdn)
      duty_r <= `FSMF_DUTY_RST;
    else if (wrEn_r && cmd_r == `FSMF_CMD_DUTY)
      duty_r <= wrData_r[3:0];
  end

  // Read mux; coarse view drops the 25 RPM bit [RULE11] [RULE10]
  always @*
  begin
    case (cmd_r)
      `FSMF_CMD_SPEED:     rdData = speed_r[8:1];
      `FSMF_CMD_SPEED_LSB: rdData = {7'h00, speed_r[0] & cfg_r[`FSMF_CFG_FINE]};
      `FSMF_CMD_CFG:       rdData = cfg_r;
      `FSMF_CMD_STATUS:    rdData = {2'h0, otf_r, 1'b0, rco_r, 2'h0, ff_r};
      `FSMF_CMD_DUTY:      rdData = {4'h0, duty_r};
      `FSMF_CMD_THR:       rdData = thr_r;
      default:             rdData = 8'h00;
    endcase
  end

  // ***************************************************************
  // Serial slave
  // ***************************************************************
  reg  [4:0] st_r;
  reg  [3:0] bitCnt_r;
  reg  [1:0] byteIdx_r;
  reg  [7:0] shift_r;
  reg        rw_r;
  reg        sdaOe_r;
  reg        mAck_r;

  // Byte engine; start restarts anywhere, so a new transfer
  // only follows an idle bus or a repeated start [RULE24]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_r      <= ST_IDLE;
      bitCnt_r  <= 4'h0;
      byteIdx_r <= 2'h0;
      shift_r   <= 8'h00;
      rw_r      <= 1'b0;
      sdaOe_r   <= 1'b0;
      mAck_r    <= 1'b0;
      cmd_r     <= 8'h00;
      wrEn_r    <= 1'b0;
      wrData_r  <= 8'h00;
    end
    else
    begin
      wrEn_r <= 1'b0;
      if (startC)
      begin
        st_r      <= ST_RX;
        bitCnt_r  <= 4'h0;
        byteIdx_r <= 2'h0;
        sdaOe_r   <= 1'b0;
      end
      else if (stopC)
      begin
        st_r    <= ST_IDLE;
        sdaOe_r <= 1'b0;
      end
      else
      begin
        case (st_r)
          ST_RX:
          begin
            // Bits are taken on the rising clock edge [RULE25]
            if (sclRise && bitCnt_r != 4'h8)
            begin
              shift_r  <= {shift_r[6:0], sdaS};
              bitCnt_r <= bitCnt_r + 4'h1;
            end
            else if (sclFall && bitCnt_r == 4'h8)
            begin
              bitCnt_r <= 4'h0;
              if (byteIdx_r == 2'h0)
              begin
                // Fixed address, no strap [RULE23]
                if (shift_r[7:1] == `FSMF_SLAVE_ADDR)
                begin
                  rw_r    <= shift_r[0];
                  sdaOe_r <= 1'b1;
                  st_r    <= ST_ACK;
                end
                else
                  st_r <= ST_IDLE;
              end
              else
              begin
                if (byteIdx_r == 2'h1)
                  cmd_r <= shift_r;
                else
                begin
                  wrEn_r   <= 1'b1;
                  wrData_r <= shift_r;
                end
                sdaOe_r <= 1'b1;
                st_r    <= ST_ACK;
              end
            end
          end
          ST_ACK:
          begin
            // Release or drive only after SCL has fallen [RULE25]
            if (sclFall)
            begin
              if (rw_r && byteIdx_r == 2'h0)
              begin
                st_r     <= ST_TX;
                shift_r  <= rdData;
                sdaOe_r  <= ~rdData[7];
                bitCnt_r <= 4'h1;
              end
              else
              begin
                sdaOe_r   <= 1'b0;
                st_r      <= ST_RX;
                byteIdx_r <= (byteIdx_r == 2'h2) ? 2'h2 : byteIdx_r + 2'h1;
              end
            end
          end
          ST_TX:
          begin
            if (sclFall)
            begin
              if (bitCnt_r == 4'h8)
              begin
                sdaOe_r <= 1'b0;
                st_r    <= ST_MACK;
              end
              else
              begin
                sdaOe_r  <= ~shift_r[6];
                shift_r  <= {shift_r[6:0], 1'b0};
                bitCnt_r <= bitCnt_r + 4'h1;
              end
            end
          end
          ST_MACK:
          begin
            if (sclRise)
              mAck_r <= ~sdaS;
            else if (sclFall)
            begin
              if (mAck_r)
              begin
                st_r     <= ST_TX;
                shift_r  <= rdData;
                sdaOe_r  <= ~rdData[7];
                bitCnt_r <= 4'h1;
              end
              else
                st_r <= ST_IDLE;
            end
          end
          default:
            st_r <= ST_IDLE;
        endcase
      end
    end
  end

  assign sdaOut = 1'b0;
  assign sdaOe  = sdaOe_r;

  // ***************************************************************
  // Startup and PWM
  // ***************************************************************
  reg  [31:0] startCnt_r;
  reg         boot_r;
  reg  [31:0] stepCnt_r;
  reg  [7:0]  phase_r;
  reg         pwm_r;

  // Full duty for one second after reset or shutdown exit [RULE1] [RULE2] [RULE21]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      boot_r     <= 1'b1;
      startCnt_r <= 32'h0;
    end
    else if (sdn)
    begin
      boot_r     <= 1'b1;
      startCnt_r <= 32'h0;
    end
    else if (boot_r)
    begin
      if (startCnt_r == STARTUP_CYC - 1)
        boot_r <= 1'b0;
      startCnt_r <= startCnt_r + 32'h1;
    end
  end

  // Source select and linear code-to-steps map [RULE5] [RULE6]
  wire [3:0] dutyCode = cfg_r[`FSMF_CFG_DSRC] ? duty_r : tcode1_r;
  wire [7:0] onSteps  = boot_r ? `FSMF_PWM_STEPS :
                        `FSMF_PWM_BASE + `FSMF_PWM_SLOPE * {4'h0, dutyCode};
  wire       stepEn   = (stepCnt_r == PWM_STEP_CYC - 1);

  // Frame keeps running through faults; only shutdown gates it [RULE3] [RULE4] [RULE20]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      stepCnt_r <= 32'h0;
      phase_r   <= 8'h00;
      pwm_r     <= 1'b0;
    end
    else if (sdn)
    begin
      stepCnt_r <= 32'h0;
      phase_r   <= 8'h00;
      pwm_r     <= 1'b0;
    end
    else
    begin
      stepCnt_r <= stepEn ? 32'h0 : stepCnt_r + 32'h1;
      if (stepEn)
        phase_r <= (phase_r == `FSMF_PWM_STEPS - 8'h01) ? 8'h00 : phase_r + 8'h01;
      pwm_r <= (phase_r < onSteps);
    end
  end

  assign pwmDriveOut = pwm_r;

  // ***************************************************************
  // Speed measurement and faults
  // ***************************************************************
  reg  [31:0] gateCnt_r;
  reg  [12:0] pulseCnt_r;
  reg         faultOut_r;

  wire        gateEnd = (gateCnt_r == GATE_CYC - 1);
  // A 2.4 s gate makes count / pulses-per-turn exactly RPM / 25 [RULE9] [RULE7]
  wire [12:0] scaled  = pulseCnt_r >> cfg_r[`FSMF_CFG_PPR_HI:`FSMF_CFG_PPR_LO];
  wire        overEv  = gateEnd & (scaled > {4'h0, `FSMF_SPEED_MAX});
  wire [8:0]  newSpd  = (scaled > {4'h0, `FSMF_SPEED_MAX}) ? `FSMF_SPEED_MAX : scaled[8:0];
  wire        lowEv   = gateEnd & (newSpd < {thr_r, 1'b0});
  wire        otCond  = ~boot_r & ~cfg_r[`FSMF_CFG_DSRC] & over1_r;

  // Gate counter and saturating pulse count, cleared to zero with speed in shutdown [RULE20]
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      gateCnt_r  <= 32'h0;
      pulseCnt_r <= 13'h0000;
      speed_r    <= 9'h000;
    end
    else if (sdn)
    begin
      gateCnt_r  <= 32'h0;
      pulseCnt_r <= 13'h0000;
      speed_r    <= 9'h000;
    end
    else if (gateEnd)
    begin
      gateCnt_r  <= 32'h0;
      pulseCnt_r <= {12'h000, tachP};
      speed_r    <= newSpd; // [RULE10]
    end
    else
    begin
      gateCnt_r <= gateCnt_r + 32'h1;
      if (tachP && pulseCnt_r != 13'h1FFF)
        pulseCnt_r <= pulseCnt_r + 13'h0001;
    end
  end

  // Status flags; a new fault wins over a same-cycle clear
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ff_r       <= 1'b0;
      rco_r      <= 1'b0;
      otf_r      <= 1'b0;
      faultOut_r <= 1'b0;
    end
    else if (sdn)
    begin
      ff_r       <= 1'b0;
      rco_r      <= 1'b0;
      otf_r      <= 1'b0;
      faultOut_r <= 1'b0;
    end
    else
    begin
      if (lowEv)
        ff_r <= 1'b1; // [RULE15] [RULE16]
      else if (ffClear)
        ff_r <= 1'b0; // [RULE17]
      if (overEv)
        rco_r <= 1'b1; // [RULE12]
      else if (gateEnd)
        rco_r <= 1'b0; // [RULE13]
      otf_r      <= otCond; // [RULE18] [RULE19]
      faultOut_r <= (ff_r & ~ffClear) | lowEv | ((OT_FAULT_EN != 0) & otCond);
    end
  end

  assign faultOut_n = ~faultOut_r;

endmodule

`default_nettype wire

// ==== sim/fsmf_core_properties.sv ====
// Concurrent checks on the fan core pins
`default_nettype none
module fsmf_props #(
  parameter STARTUP_CYC = 200
) (
  input wire logic mclk,          // Core clock
  input wire logic reset,         // Async reset
  input wire logic sclIn,         // Serial clock pin
  input wire logic sdaOut,        // Serial data drive value
  input wire logic sdaOe,         // Serial data pull enable
  input wire logic pwmDriveOut,   // Fan drive
  input wire logic faultOut_n     // Fault pin, active low
);
  timeunit 1ns;
  timeprecision 100ps;
  // ************************************************************
  // Helper count and assertions
  // ************************************************************
  logic [15:0] upCnt_r;           // Cycles since reset release, saturating
  // Saturate so a long run never wraps back into the start-up window
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      upCnt_r <= 16'h0000;
    else if (upCnt_r != 16'hFFFF)
      upCnt_r <= upCnt_r + 16'h0001;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // Ack plus eight zero bits is the longest the slave may hold the line
  a_sda_open: assert property ($rose(sdaOe) |-> (sdaOut == 1'b0) ##[1:320] !sdaOe)
    else $error("data line held low too long");
  a_startup_full: assert property (
    upCnt_r > 16'h0002 && upCnt_r < STARTUP_CYC - 2 |-> pwmDriveOut)
    else $error("fan drive low during start-up");
  a_reset_quiet: assert property ($fell(reset) |-> faultOut_n && !sdaOe)
    else $error("fault or data pull active out of reset");
  a_sda_lowclk: assert property ($changed(sdaOe) |-> !sclIn)
    else $error("data pull changed while clock high");
  a_ack_hold: assert property ($rose(sdaOe) |=> sdaOe [*8])
    else $error("data pull too short");
  a_fault_pulses: assert property (
    $fell(pwmDriveOut) && !faultOut_n |-> ##[1:700] $rose(pwmDriveOut))
    else $error("fan drive stopped under fault");
  a_fault_hold: assert property ($fell(faultOut_n) |=> !faultOut_n [*8])
    else $error("fault pin glitched");
  a_pwm_minhigh: assert property ($rose(pwmDriveOut) |=> pwmDriveOut [*8])
    else $error("fan drive high phase too short");
  c_fault: cover property (!faultOut_n);
  c_ack: cover property ($rose(sdaOe));
  c_fault_pwm: cover property ($fell(pwmDriveOut) && !faultOut_n);
endmodule
bind fsmf_core fsmf_props #(.STARTUP_CYC(STARTUP_CYC)) fsmf_props_inst (.mclk, .reset,
  .sclIn, .sdaOut, .sdaOe, .pwmDriveOut, .faultOut_n);
`default_nettype wire

// ==== sim/fsmf_host_model.sv ====
// Two-wire bus master model that reaches the fan core registers
`include "fsmf_consts.vh"
`default_nettype none
module fsmf_host_model (
  input  wire logic sdaLine,      // Resolved data line
  output var  logic sclLine,      // Serial clock, stands high when idle
  output var  logic sdaLow        // High while the master pulls data low
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus starts idle: clock high, data released
  initial
  begin
    sclLine = 1'b1;
    sdaLow  = 1'b0;
  end
  // ************************************************************
  // Bit, byte and transfer tasks
  // ************************************************************
  // Quarter steps of a 160 ns link period, free of the core clock phase
  task automatic bitX(input logic bi, output logic bo);
    #40.3 sdaLow = !bi;
    #40 sclLine = 1'b1;
    #40 bo = sdaLine;
    #40 sclLine = 1'b0;
  endtask
  // Also serves as repeated start, since data is released first
  task automatic busStart();
    #40.3 sdaLow = 1'b0;
    #40 sclLine = 1'b1;
    #40 sdaLow = 1'b1;
    #40 sclLine = 1'b0;
  endtask
  task automatic busStop();
    #40.3 sdaLow = 1'b1;
    #40 sclLine = 1'b1;
    #40 sdaLow = 1'b0;
    #40;
  endtask
  // Master always releases the ninth bit: slave acks writes, master nacks reads
  task automatic xfer(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--)
      bitX(d[i], r[i]);
    bitX(1'b1, a);
    ack = !a;
  endtask
  task automatic probe(input logic [6:0] addr, output logic ok);
    logic [7:0] r;
    busStart();
    xfer({addr, 1'b0}, r, ok);
    busStop();
  endtask
  task automatic regWrite(input logic [7:0] cmd, input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    busStart();
    xfer({`FSMF_SLAVE_ADDR, 1'b0}, r, a0);
    xfer(cmd, r, a1);
    xfer(data, r, a2);
    busStop();
    ok = a0 & a1 & a2;
  endtask
  task automatic regRead(input logic [7:0] cmd, output logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    busStart();
    xfer({`FSMF_SLAVE_ADDR, 1'b0}, r, a0);
    xfer(cmd, r, a1);
    busStart();
    xfer({`FSMF_SLAVE_ADDR, 1'b1}, r, a2);
    xfer(8'hFF, d, a3);
    busStop();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ==== sim/fsmf_core_tb.sv ====
// Self-checking bench for the fan speed monitor and fault control core
`include "fsmf_consts.vh"
`default_nettype none
module fsmf_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STARTUP = 2000;  // Shortened start-up hold
  localparam int GATE = 1200;     // Shortened gate, a multiple of every tach period
  localparam int PSTEP = 4;       // Shortened PWM step
  localparam int FRAME = 150 * PSTEP;
  localparam int WAITG = 2 * GATE + 200; // Guarantees one whole gate after a change
  logic mclk, reset, senseIn, tempOverRange, sclLine, sdaLow;
  logic [3:0] tempDutyCode;
  wire logic sdaOe, sdaOut, pwmDriveOut, faultOut_n;
  wire logic sdaLine = !(sdaLow | sdaOe); // Pull-up unless a party pulls
  integer seed = 32'hA9D3;
  int n_fail = 0, comparisons = 0, cycles = 0, tachPer = 0, tachCnt = 0;
  int pers[4] = '{8, 12, 24, 40};
  fsmf_core #(.STARTUP_CYC(STARTUP), .GATE_CYC(GATE), .PWM_STEP_CYC(PSTEP), .OT_FAULT_EN(1))
    fsmf_core_inst (.mclk, .reset, .sclIn(sclLine), .sdaIn(sdaLine), .sdaOut, .sdaOe, .senseIn,
    .tempDutyCode, .tempOverRange, .pwmDriveOut, .faultOut_n);
  fsmf_host_model fsmf_host_model_inst (.sdaLine, .sclLine, .sdaLow);
  // ************************************************************
  // Clock, tach source, timeout and helpers
  // ************************************************************
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Tach pulses at a steady period; the cycle ceiling cuts a hang short
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    tachCnt <= tachCnt + 1 >= tachPer ? 0 : tachCnt + 1;
    senseIn <= tachPer != 0 && tachCnt < tachPer / 2;
    if (cycles == 95000)
    begin
      n_fail++;
      conclude();
    end
  end
  task automatic chkCnt(string what, logic [15:0] exp, logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chkReg(string what, logic [7:0] exp, logic [7:0] got);
    chkCnt(what, {8'h00, exp}, {8'h00, got});
  endtask
  task automatic chkPin(string what, logic exp, logic got);
    chkCnt(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic rdChk(string what, logic [7:0] cmd, logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    @(posedge mclk);
    fsmf_host_model_inst.regRead(cmd, d, ok);
    chkPin("read ack", 1'b1, ok);
    chkReg(what, exp, d);
  endtask
  task automatic wr(logic [7:0] cmd, logic [7:0] data);
    logic ok;
    @(posedge mclk);
    fsmf_host_model_inst.regWrite(cmd, data, ok);
    chkPin("write ack", 1'b1, ok);
  endtask
  // Highs over one whole frame after one frame of settling
  task automatic pwmChk(int steps);
    int n;
    n = 0;
    repeat (FRAME) @(posedge mclk);
    repeat (FRAME) @(posedge mclk) n += pwmDriveOut;
    chkCnt("pwm high cycles", 16'(steps * PSTEP), 16'(n));
  endtask
  function automatic int dutySteps(logic [3:0] code);
    return `FSMF_PWM_BASE + `FSMF_PWM_SLOPE * code;
  endfunction
  function automatic logic [8:0] speedOf(int per, logic [1:0] ppr);
    int p;
    p = (GATE / per) >> ppr;
    return p > 511 ? 9'h1FF : 9'(p);
  endfunction
  task automatic conclude();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [8:0] spd;
    logic [3:0] code;
    logic ok;
    int per;
    reset = 1'b1;
    tempOverRange = 1'b0;
    tempDutyCode = 4'h2;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    chkPin("pwm at start", 1'b1, pwmDriveOut);
    rdChk("cfg", `FSMF_CMD_CFG, `FSMF_CFG_RST);
    rdChk("thr", `FSMF_CMD_THR, `FSMF_THR_RST);
    rdChk("duty", `FSMF_CMD_DUTY, {4'h0, `FSMF_DUTY_RST});
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      fsmf_host_model_inst.probe(i == 0 ? 7'h1A : i == 1 ? 7'h5B : {1'b1, 6'($random(seed))}, ok);
      chkPin("foreign ack", 1'b0, ok);
    end
    wr(`FSMF_CMD_STATUS, 8'hFF);
    // No tach yet, so the first gate already flagged a fan failure
    rdChk("status ro", `FSMF_CMD_STATUS, 8'h01);
    rdChk("unmapped", 8'h07, 8'h00);
    wr(`FSMF_CMD_THR, 8'h00);
    for (int p = 0; p < 4; p++)
    begin
      per = pers[$unsigned($random(seed)) % 4];
      tachPer <= per;
      wr(`FSMF_CMD_CFG, {1'b1, p[0], 3'b000, p[1:0], 1'b0});
      repeat (WAITG) @(posedge mclk);
      spd = speedOf(per, p[1:0]);
      rdChk("speed high", `FSMF_CMD_SPEED, spd[8:1]);
      rdChk("speed low", `FSMF_CMD_SPEED_LSB, {7'h00, spd[0] & p[0]});
    end
    tachPer <= 2;
    wr(`FSMF_CMD_CFG, 8'h40);
    repeat (WAITG) @(posedge mclk);
    rdChk("speed max", `FSMF_CMD_SPEED, 8'hFF);
    rdChk("status ovf", `FSMF_CMD_STATUS, 8'h08);
    tachPer <= 8;
    repeat (WAITG) @(posedge mclk);
    rdChk("status ovf", `FSMF_CMD_STATUS, 8'h00);
    tachPer <= 0;
    wr(`FSMF_CMD_THR, 8'(($unsigned($random(seed)) % 255) + 1));
    wr(`FSMF_CMD_CFG, 8'h22);
    repeat (WAITG) @(posedge mclk);
    chkPin("fault pin", 1'b0, faultOut_n);
    rdChk("status fail", `FSMF_CMD_STATUS, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      code = i == 0 ? 4'h0 : i == 1 ? 4'hF : 4'($random(seed));
      if (i == 4)
        wr(`FSMF_CMD_CFG, 8'h02);
      tempDutyCode <= ~code;
      wr(`FSMF_CMD_DUTY, {4'h0, code});
      pwmChk(dutySteps(i < 4 ? code : ~code));
    end
    wr(`FSMF_CMD_THR, 8'h00);
    wr(`FSMF_CMD_CFG, 8'h82);
    chkPin("fault released", 1'b1, faultOut_n);
    rdChk("status clear", `FSMF_CMD_STATUS, 8'h00);
    tachPer <= 8; // Fan up to speed long before the shutdown threshold lands
    tempOverRange <= 1'b1;
    repeat (20) @(posedge mclk);
    chkPin("ot fault", 1'b0, faultOut_n);
    rdChk("status ot", `FSMF_CMD_STATUS, 8'h20);
    tempOverRange <= 1'b0;
    repeat (20) @(posedge mclk);
    chkPin("ot release", 1'b1, faultOut_n);
    rdChk("status ot", `FSMF_CMD_STATUS, 8'h00);
    tempDutyCode <= 4'h2;
    wr(`FSMF_CMD_THR, 8'h21);
    wr(`FSMF_CMD_DUTY, 8'h09);
    // Enter shutdown well away from a rising PWM edge
    @(posedge pwmDriveOut);
    wr(`FSMF_CMD_CFG, 8'h23);
    pwmChk(0);
    rdChk("thr kept", `FSMF_CMD_THR, 8'h21);
    wr(`FSMF_CMD_CFG, 8'h22);
    pwmChk(150);
    rdChk("duty default", `FSMF_CMD_DUTY, {4'h0, `FSMF_DUTY_RST});
    rdChk("cfg kept", `FSMF_CMD_CFG, 8'h22);
    conclude();
  end
endmodule
`default_nettype wire
